// file: inc/ptc_pkg.sv
// Package for the transmit-path pattern checker: map, fields, types
package ptc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] PTC_IDX_CTRL = 6'h39;
    localparam logic [5:0] PTC_IDX_TOTAL = 6'h3A;
    localparam int PTC_ADDR_W = 8;
    localparam int PTC_DATA_W = 32;
    localparam int PTC_REG_W = 16;

    // Control and status field positions
    localparam int PTC_BIT_ENABLE = 0;
    localparam int PTC_BIT_MODE = 1;
    localparam int PTC_BIT_OVF = 2;
    localparam int PTC_BIT_LOCKED = 4;
    localparam int PTC_BIT_SYNC_LOST = 5;
    localparam int PTC_ERR_LSB = 7;
    localparam int PTC_ERR_MSB = 14;
    localparam int PTC_BIT_FREEZE = 7;
    localparam int PTC_BIT_FREEZE_CLR = 8;

    // Count widths and limits
    localparam int PTC_ERR_W = 8;
    localparam int PTC_TOT_W = 16;
    localparam logic [7:0] PTC_ERR_MAX = 8'hFF;
    localparam logic [15:0] PTC_TOT_MAX = 16'hFFFF;
    localparam logic [15:0] PTC_RESET_VAL = 16'h0000;

    // Lock qualification
    localparam int PTC_RUN_W = 3;
    localparam logic [2:0] PTC_GOOD_TO_LOCK = 3'h4;
    localparam logic [2:0] PTC_BAD_TO_LOSE = 3'h4;

    // Bus responses
    localparam logic [1:0] PTC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PTC_RESP_SLVERR = 2'h2;

    // Pattern generator seed width (x^7 + x^6 + 1)
    localparam int PTC_SEED_W = 7;

    typedef logic [7:0] ptc_byte_t;

    typedef enum logic [1:0] {
        PTC_HUNT = 2'b01,
        PTC_LOCK = 2'b10
    } ptc_state_t;

    typedef struct packed {
        logic mode;
        logic enable;
    } ptc_ctrl_t;

    typedef struct packed {
        logic [7:0] err;
        logic [15:0] total;
    } ptc_counts_t;

    // Next eight pattern bits, oldest in the top bit
    function automatic ptc_byte_t ptc_predict(input logic [6:0] seed);
        logic [6:0] s;
        ptc_byte_t b;
        s = seed;
        b = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            b[i] = s[6] ^ s[5];
            s = {s[5:0], b[i]};
        end
        return b;
    endfunction : ptc_predict

endpackage : ptc_pkg

// file: src/ptc_buffer.sv
// Two-entry valid/ready buffer in the looped-back byte path
`timescale 1ns/1ps
`default_nettype none
module ptc_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = store[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + CW'(1);
        end else if (pop && !push) begin
            next_count = count - CW'(1);
        end
    end

    // Occupancy and flags
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            count <= next_count;
            in_ready <= (next_count < CW'(DEPTH));
            out_valid <= (next_count != '0);
        end
    end

    // Storage and pointers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                store[wr_ptr] <= in_data;
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
            end
        end
    end
endmodule : ptc_buffer
`default_nettype wire

// file: src/ptc_checker.sv
// Transmit-path pattern checker with AXI4-Lite register access
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ptc_checker #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [ptc_pkg::PTC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ptc_pkg::PTC_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ptc_pkg::PTC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [ptc_pkg::PTC_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire ptc_pkg::ptc_byte_t loop_data,
    input wire logic loop_valid,
    output logic loop_ready
);
    import ptc_pkg::*;

    ptc_ctrl_t ctrl;
    ptc_counts_t live;
    ptc_counts_t shown;
    ptc_state_t state;
    logic overflow;
    logic sync_lost;
    logic freeze_pulse;
    logic clear_pulse;

    logic aw_full;
    logic w_full;
    logic next_aw_full;
    logic next_w_full;
    logic [PTC_ADDR_W-1:0] aw_addr;
    logic [PTC_DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic wr_ctrl;
    logic wr_hit;
    logic rd_take;
    logic rd_ctrl;
    logic rd_total;
    logic [PTC_REG_W-1:0] ctrl_word;

    ptc_byte_t buf_data;
    logic buf_valid;
    logic chk_ready;
    logic take;
    logic [PTC_SEED_W-1:0] seed;
    logic seed_valid;
    logic match;
    logic [PTC_RUN_W-1:0] good_run;
    logic [PTC_RUN_W-1:0] bad_run;
    logic lose_now;
    logic loss_present;

    // Byte path buffer; stalls while disabled or clearing
    ptc_buffer #(
        .WIDTH(8),
        .DEPTH(BUF_DEPTH)
    ) u_buffer (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_data(loop_data),
        .in_valid(loop_valid),
        .in_ready(loop_ready),
        .out_data(buf_data),
        .out_valid(buf_valid),
        .out_ready(chk_ready)
    );

    assign chk_ready = ctrl.enable && !clear_pulse;
    assign take = buf_valid && chk_ready;
    assign match = (buf_data == ptc_predict(seed));

    // Write channel capture
    always_comb begin
        next_aw_full = aw_full;
        next_w_full = w_full;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
        end
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
        end
    end

    assign do_write = aw_full && w_full && !s_axi_bvalid;
    assign wr_ctrl = do_write && (aw_addr[PTC_ADDR_W-1:2] == PTC_IDX_CTRL);
    assign wr_hit = wr_ctrl ||
        (aw_addr[PTC_ADDR_W-1:2] == PTC_IDX_TOTAL);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            s_axi_awready <= !next_aw_full;
            s_axi_wready <= !next_w_full;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // Write response
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PTC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? PTC_RESP_OKAY : PTC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control bits and freeze pulses
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl <= '0;
            freeze_pulse <= 1'b0;
            clear_pulse <= 1'b0;
        end else begin
            freeze_pulse <= 1'b0;
            clear_pulse <= 1'b0;
            if (wr_ctrl && w_strb[0]) begin
                ctrl.enable <= w_data[PTC_BIT_ENABLE];
                ctrl.mode <= w_data[PTC_BIT_MODE];
                freeze_pulse <= w_data[PTC_BIT_FREEZE];
            end
            if (wr_ctrl && w_strb[1]) begin
                clear_pulse <= w_data[PTC_BIT_FREEZE_CLR];
            end
        end
    end

    // Read channel
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign rd_ctrl = (s_axi_araddr[PTC_ADDR_W-1:2] == PTC_IDX_CTRL);
    assign rd_total = (s_axi_araddr[PTC_ADDR_W-1:2] == PTC_IDX_TOTAL);

    always_comb begin
        ctrl_word = '0;
        ctrl_word[PTC_BIT_ENABLE] = ctrl.enable;
        ctrl_word[PTC_BIT_MODE] = ctrl.mode;
        ctrl_word[PTC_BIT_OVF] = overflow;
        ctrl_word[PTC_BIT_LOCKED] = (state == PTC_LOCK);
        ctrl_word[PTC_BIT_SYNC_LOST] = sync_lost;
        ctrl_word[PTC_ERR_MSB:PTC_ERR_LSB] = shown.err;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= PTC_RESP_OKAY;
        end else if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= '0;
            s_axi_rresp <= PTC_RESP_OKAY;
            if (rd_ctrl) begin
                s_axi_rdata[PTC_REG_W-1:0] <= ctrl_word;
            end else if (rd_total) begin
                s_axi_rdata[PTC_REG_W-1:0] <= shown.total;
            end else begin
                s_axi_rresp <= PTC_RESP_SLVERR;
            end
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Pattern tracking: each byte reseeds the predictor
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            seed <= '0;
            seed_valid <= 1'b0;
        end else if (!ctrl.enable) begin
            seed_valid <= 1'b0;
        end else if (take) begin
            seed <= buf_data[PTC_SEED_W-1:0];
            seed_valid <= 1'b1;
        end
    end

    assign lose_now = take && seed_valid && !match &&
        (state == PTC_LOCK) && (bad_run == PTC_BAD_TO_LOSE - 3'h1);
    assign loss_present = ctrl.enable && (state != PTC_LOCK);

    // Lock state machine
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= PTC_HUNT;
            good_run <= '0;
            bad_run <= '0;
        end else if (!ctrl.enable) begin
            state <= PTC_HUNT;
            good_run <= '0;
            bad_run <= '0;
        end else if (take && seed_valid) begin
            case (state)
                PTC_HUNT: begin
                    bad_run <= '0;
                    if (!match) begin
                        good_run <= '0;
                    end else if (good_run == PTC_GOOD_TO_LOCK - 3'h1) begin
                        good_run <= '0;
                        state <= PTC_LOCK;
                    end else begin
                        good_run <= good_run + 3'h1;
                    end
                end
                PTC_LOCK: begin
                    good_run <= '0;
                    if (match) begin
                        bad_run <= '0;
                    end else if (lose_now) begin
                        bad_run <= '0;
                        state <= PTC_HUNT;
                    end else begin
                        bad_run <= bad_run + 3'h1;
                    end
                end
                default: begin
                    state <= PTC_HUNT;
                    good_run <= '0;
                    bad_run <= '0;
                end
            endcase
        end
    end

    // Latched loss of sync; a new loss wins over the read clear
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sync_lost <= 1'b0;
        end else if (lose_now) begin
            sync_lost <= 1'b1;
        end else if (rd_take && rd_ctrl && !loss_present) begin
            sync_lost <= 1'b0;
        end
    end

    // Total byte counter and overflow
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            live.total <= PTC_RESET_VAL;
            overflow <= 1'b0;
        end else if (clear_pulse) begin
            live.total <= PTC_RESET_VAL;
            overflow <= 1'b0;
        end else if (take) begin
            if (live.total != PTC_TOT_MAX) begin
                live.total <= live.total + 16'h0001;
            end else begin
                overflow <= 1'b1;
                if (ctrl.mode) begin
                    live.total <= PTC_RESET_VAL;
                end else begin
                    live.total <= PTC_TOT_MAX;
                end
            end
        end
    end

    // Errored byte counter, counted while locked
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            live.err <= '0;
        end else if (clear_pulse) begin
            live.err <= '0;
        end else if (take && seed_valid && !match && state == PTC_LOCK) begin
            if (live.err != PTC_ERR_MAX) begin
                live.err <= live.err + 8'h01;
            end else if (ctrl.mode) begin
                live.err <= '0;
            end else begin
                live.err <= PTC_ERR_MAX;
            end
        end
    end

    // Frozen copies seen by software
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            shown <= '0;
        end else if (freeze_pulse || clear_pulse) begin
            shown <= live;
        end
    end
endmodule : ptc_checker
`default_nettype wire

// file: verification/ptc_checker_sva.sv
// Bus and stream assertions for the pattern checker
`timescale 1ns/1ps
`default_nettype none
module ptc_checker_sva (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic loop_valid,
    input wire logic loop_ready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    chk_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer missing");
    chk_rd_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    chk_rdata_upper: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    chk_wr_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer missing");
    chk_b_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer not held");
    chk_b_cause: assert property (
        $rose(s_axi_bvalid) |-> $past(s_axi_awvalid || s_axi_wvalid, 2))
        else $error("write answer without request");
    chk_release_ready: assert property (
        $fell(reset) |=> s_axi_awready && s_axi_arready ##0 loop_ready)
        else $error("readies late after reset");
    chk_ready_fall: assert property (
        $fell(loop_ready) |-> $past(loop_valid))
        else $error("stream ready fell without a byte");
endmodule : ptc_checker_sva
bind ptc_checker ptc_checker_sva i_sva (.sys_clk, .reset, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .loop_valid, .loop_ready);
`default_nettype wire

// file: verification/ptc_loop_model.sv
// Reverse-loop source returning the test pattern to the checker
`timescale 1ns/1ps
`default_nettype none
module ptc_loop_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [16:0] n,
    input wire logic [31:0] mask,
    input wire logic gap,
    output logic [7:0] loop_data,
    output logic loop_valid,
    input wire logic loop_ready,
    output logic idle
);
    logic [16:0] rem;
    logic [16:0] idx;
    logic [6:0] s;
    logic [14:0] nx;
    logic ph;
    logic bad;

    // Next byte, oldest bit in the top place, then the new state
    function automatic logic [14:0] step(input logic [6:0] v);
        logic [7:0] o;
        for (int i = 7; i >= 0; i--) begin
            o[i] = v[6] ^ v[5];
            v = {v[5:0], o[i]};
        end
        return {o, v};
    endfunction : step

    assign nx = step(s);
    assign bad = (idx < 17'd32) && mask[idx[4:0]];
    assign idle = (rem == 17'h0) && !loop_valid;

    // Top bit flip leaves the next prediction intact
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rem <= 17'h0;
            idx <= 17'h0;
            s <= 7'h01;
            ph <= 1'b0;
            loop_valid <= 1'b0;
            loop_data <= 8'h00;
        end else begin
            ph <= ~ph;
            if (start) begin
                rem <= n;
                idx <= 17'h0;
            end else if (!loop_valid || loop_ready) begin
                if (rem != 17'h0 && (!gap || ph)) begin
                    loop_valid <= 1'b1;
                    loop_data <= nx[14:7] ^ {bad, 7'h00};
                    s <= nx[6:0];
                    rem <= rem - 17'h1;
                    idx <= idx + 17'h1;
                end else begin
                    loop_valid <= 1'b0;
                    loop_data <= ~loop_data;
                end
            end
        end
    end
endmodule : ptc_loop_model
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the pattern checker
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ptc_pkg::*;
    typedef struct {
        logic md; logic gp; logic [16:0] n; logic [31:0] msk;
        logic [15:0] tot; logic [7:0] er; logic lk; logic ls;
    } ptc_row_t;
    localparam logic [7:0] CA = 8'hE4;
    localparam logic [7:0] TA = 8'hE8;
    logic sys_clk = 0, reset = 1, start = 0, gap = 0;
    logic [16:0] n = 0;
    logic [31:0] msk = 0, wdata = 0, rdata, d;
    logic [7:0] awaddr = 0, araddr = 0, ldata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, lvalid, lready, idle;
    logic [1:0] bresp, rresp, r;
    int errors = 0, num_checks = 0;
    ptc_row_t rows[4] = '{'{0, 0, 3, 0, 3, 0, 0, 0},
        '{0, 1, 20, 0, 20, 0, 1, 0}, '{0, 0, 20, 32'h5000, 20, 2, 1, 0},
        '{1, 0, 20, 32'h3FC00, 20, 4, 0, 1}};
    ptc_checker i_dut (.sys_clk, .reset, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .loop_data(ldata), .loop_valid(lvalid),
        .loop_ready(lready));
    ptc_loop_model i_loop (.sys_clk, .reset, .start, .n, .mask(msk), .gap,
        .loop_data(ldata), .loop_valid(lvalid), .loop_ready(lready), .idle);
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic results;
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tmo(input int t, input int lim);
        if (t >= lim) begin
            errors++;
            $display("ERROR %0t: wait timed out", $time);
            results();
        end
    endtask : tmo
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
            input logic [1:0] er);
        int t;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (t = 0; t < 50; t++) begin
            @(posedge sys_clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) break;
        end
        bready <= 0;
        tmo(t, 50);
        chk(bresp, er);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
            output logic [1:0] rs);
        int t;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (t = 0; t < 50; t++) begin
            @(posedge sys_clk);
            if (arready) arvalid <= 0;
            if (rvalid) break;
        end
        v = rdata;
        rs = rresp;
        rready <= 0;
        tmo(t, 50);
    endtask : rd
    task automatic send(input logic [16:0] cnt, input logic [31:0] m,
            input logic g);
        n <= cnt;
        msk <= m;
        gap <= g;
        start <= 1;
        @(posedge sys_clk);
        start <= 0;
    endtask : send
    task automatic drain;
        int t;
        @(posedge sys_clk);
        for (t = 0; t < 70000; t++) begin
            @(posedge sys_clk);
            if (idle) break;
        end
        tmo(t, 70000);
        repeat (4) @(posedge sys_clk);
    endtask : drain
    initial begin
        repeat (20) @(posedge sys_clk);
        reset <= 0;
        foreach (rows[i]) begin
            wr(CA, 32'h100, PTC_RESP_OKAY);
            wr(CA, {30'h0, rows[i].md, 1'b1}, PTC_RESP_OKAY);
            send(rows[i].n, rows[i].msk, rows[i].gp);
            drain();
            wr(CA, {24'h0, 1'b1, 5'h0, rows[i].md, 1'b1}, 0);
            rd(TA, d, r);
            chk(d, {16'h0, rows[i].tot});
            rd(CA, d, r);
            chk(d, {17'h0, rows[i].er, 1'b0, rows[i].ls, rows[i].lk,
                2'b00, rows[i].md, 1'b1});
        end
        wr(CA, 32'h0, PTC_RESP_OKAY);
        rd(CA, d, r);
        chk(d, 32'h220);
        rd(CA, d, r);
        chk(d, 32'h200);
        wr(CA, 32'h101, PTC_RESP_OKAY);
        send(5, 0, 0);
        drain();
        wr(CA, 32'h81, PTC_RESP_OKAY);
        send(5, 0, 0);
        drain();
        rd(TA, d, r);
        chk(d, 32'h5);
        wr(CA, 32'h101, PTC_RESP_OKAY);
        rd(TA, d, r);
        chk(d, 32'hA);
        wr(CA, 32'h80, PTC_RESP_OKAY);
        rd(TA, d, r);
        chk(d, 32'h0);
        send(3, 0, 0);
        repeat (10) @(posedge sys_clk);
        chk({idle, lready}, 2'b00);
        wr(CA, 32'h1, PTC_RESP_OKAY);
        drain();
        wr(CA, 32'h81, PTC_RESP_OKAY);
        rd(TA, d, r);
        chk(d, 32'h3);
        wr(CA, 32'h101, PTC_RESP_OKAY);
        send(17'h10001, 0, 0);
        drain();
        wr(CA, 32'h81, PTC_RESP_OKAY);
        rd(TA, d, r);
        chk(d, 32'hFFFF);
        rd(CA, d, r);
        chk(d & 32'h4, 32'h4);
        rd(8'h00, d, r);
        chk({r, d}, {PTC_RESP_SLVERR, 32'h0});
        wr(8'h00, 32'h1, PTC_RESP_SLVERR);
        reset <= 1;
        repeat (2) @(posedge sys_clk);
        reset <= 0;
        rd(CA, d, r);
        chk({r, d}, 34'h0);
        rd(TA, d, r);
        chk({r, d}, 34'h0);
        results();
    end
endmodule : tb
`default_nettype wire
